// [include/irq_ctrl_consts.svh]
// Register offsets, field positions and reset values of the interrupt controller
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_REQUEST    4'h0
`define OFS_MASK       4'h1
`define OFS_PRIORITY   4'h2
`define OFS_PORT3_MODE 4'h3
`define OFS_PIN_STATE  4'h4
`define OFS_EVT_STAT   4'h5
`define OFS_EVT_CLEAR  4'h6
`define OFS_EVT_ENABLE 4'h7

// ****************************************************************
// Field positions
// ****************************************************************
`define SRC_COUNT      6
`define REQ_EDGE_LO    6
`define REQ_SPREAD_BIT 3
`define MASK_GLOBAL    7
`define P3M_ANALOG     1
`define EVT_VECTOR     6
`define EVT_WIDTH      7

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_REQUEST    8'h00
`define RST_MASK       8'h00
`define RST_PRIORITY   3'h0
`define RST_EVT        7'h00

`endif

// [include/irq_ctrl_pkg.sv]
// Types shared by the interrupt controller modules
package irq_ctrl_pkg;

  // Interrupt machine cycle, Gray coded along the path
  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_SAVE     = 3'h1,
    ST_FETCH_HI = 3'h3,
    ST_FETCH_LO = 3'h2,
    ST_LOAD     = 3'h6
  } cyc_state_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } edge_mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
  } pm_req_t;

  // Edge pair selection: returns the mode of the timer input or the time base
  function automatic edge_mode_t edge_mode(input logic [1:0] sel, input logic time_base);
    edge_mode_t m;
    m = '{rise: 1'b0, fall: 1'b1};
    case (sel)
      2'b00: m = '{rise: 1'b0, fall: 1'b1};
      2'b01: m = time_base ? '{rise: 1'b1, fall: 1'b0} : '{rise: 1'b0, fall: 1'b1};
      2'b10: m = time_base ? '{rise: 1'b0, fall: 1'b1} : '{rise: 1'b1, fall: 1'b0};
      2'b11: m = '{rise: 1'b1, fall: 1'b1};
      default: m = '{rise: 1'b0, fall: 1'b1};
    endcase
    return m;
  endfunction : edge_mode

endpackage : irq_ctrl_pkg

// [rtl/edge_watch.sv]
// Selectable rising/falling edge detector for one request input
`timescale 1ns/1ps
`default_nettype none
module edge_watch
  import irq_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Sampled level and edge choice
  input  wire logic       level,
  input  wire edge_mode_t mode,
  // One-cycle edge pulse
  output logic            hit
);

  typedef struct packed {
    logic prev;
    logic primed;
  } watch_state_t;

  watch_state_t s_q;
  watch_state_t s_d;

  always_comb begin
    s_d        = s_q;
    s_d.prev   = level;
    s_d.primed = 1'b1;
  end

  // No edge before the first sample, so a level present at reset is not an edge
  assign hit = s_q.primed &
               ((mode.rise & level & ~s_q.prev) | (mode.fall & ~level & s_q.prev));

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : edge_watch
`default_nettype wire

// [rtl/prio_pick.sv]
// Rotating priority encoder over the pending requests
`timescale 1ns/1ps
`default_nettype none
module prio_pick #(
  parameter int unsigned N = 6
) (
  // Pending requests and first-served position
  input  wire logic [N-1:0]         pend,
  input  wire logic [2:0]           start,
  // Winner
  output logic                      valid,
  output logic [2:0]                win
);

  always_comb begin
    int unsigned idx;
    int unsigned base;
    idx   = 0;
    base  = (int'(start) < N) ? int'(start) : 0;
    valid = 1'b0;
    win   = 3'h0;
    // Highest priority goes to 'start', then ascending with wrap
    for (int k = N - 1; k >= 0; k--) begin
      idx = (base + k) % N;
      if (pend[idx]) begin
        valid = 1'b1;
        win   = 3'(idx);
      end
    end
  end

endmodule : prio_pick
`default_nettype wire

// [rtl/irq_ctrl.sv]
// Six-source vectored, maskable, prioritised interrupt controller
//
// How it works
// - six requests, each maskable and prioritised
// - two pins, two timers, modulator, time base
// - mask has global and per-request enables
// - request n vectors through bytes 2n, 2n+1
// - two vector bytes form 16-bit routine address
// - priority register steers the rotating encoder
// - grant saves context, disables, fetches vector
// - falling reference pin edge raises its request
// - port3 mode bit one powers the comparator
// - analog mode uses stop-recovery source instead
// - software raises modulator request via bit three
// - modulator reload raises request while enabled
// - timer input from comparator in analog, time base fixed
// - those two pick rising, falling or both
// - flags still set while masked, pollable
// - timer end of count raises its request
// - request bits seven, six encode edge pair
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`include "irq_ctrl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl
  import irq_ctrl_pkg::*;
#(
  parameter int unsigned SRC = `SRC_COUNT
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire reg_req_t    reg_req,
  output logic [7:0]       reg_rdata,
  // Request sources
  input  wire logic        reference_pin,
  input  wire logic        analog_timer_pin,
  input  wire logic        comparator_out,
  input  wire logic        stop_recovery_src,
  input  wire logic        time_base_level,
  input  wire logic        timer_zero_eoc,
  input  wire logic        timer_one_eoc,
  input  wire logic        spread_enable,
  input  wire logic        spread_reload,
  // Analog front end
  output logic             comparator_power,
  // Processor core
  input  wire logic        core_int_ok,
  output logic             int_pending,
  output logic             core_save_ctx,
  output logic             core_load_pc,
  output logic [15:0]      isr_addr,
  // Program memory vector fetch
  output pm_req_t          pm_req,
  input  wire logic [7:0]  pm_rdata,
  // Event interrupt
  output logic             irq_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  // All state in one struct: one comb copy, one register
  typedef struct packed {
    logic [SRC-1:0]          req;
    logic [1:0]              edge_sel;
    logic [7:0]              mask;
    logic [2:0]              prio;
    logic                    analog;
    logic [`EVT_WIDTH-1:0]   evt;
    logic [`EVT_WIDTH-1:0]   evt_en;
    logic [7:0]              rdata;
    cyc_state_t              st;
    logic [2:0]              win;
    logic [7:0]              vec_hi;
    logic [15:0]             isr;
    logic [15:0]             pm_addr;
    logic                    load;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;

  // Byte address of the first vector byte of a request
  function automatic logic [15:0] vec_base(input logic [2:0] idx);
    return {12'h000, idx, 1'b0};
  endfunction : vec_base

  // ****************************************************************
  // Source routing
  // ****************************************************************
  logic       ref_level;
  logic       tin_level;
  logic       ref_hit;
  logic       tin_hit;
  logic       tb_hit;
  edge_mode_t tin_mode;
  edge_mode_t tb_mode;
  edge_mode_t ref_mode;

  // A mode switch can show a false edge if the two sources differ
  // comparator power
  assign comparator_power = s_q.analog;
  assign ref_level = s_q.analog ? stop_recovery_src : reference_pin;
  assign tin_level = s_q.analog ? comparator_out : analog_timer_pin;
  assign tin_mode  = edge_mode(s_q.edge_sel, 1'b0);
  assign tb_mode   = edge_mode(s_q.edge_sel, 1'b1);

  assign ref_mode  = '{rise: 1'b0, fall: 1'b1};

  edge_watch u_ref_edge (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .level   (ref_level),
    .mode    (ref_mode),
    .hit     (ref_hit)
  );

  edge_watch u_tin_edge (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .level   (tin_level),
    .mode    (tin_mode),
    .hit     (tin_hit)
  );

  edge_watch u_tb_edge (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .level   (time_base_level),
    .mode    (tb_mode),
    .hit     (tb_hit)
  );

  logic [SRC-1:0] hw_set;
  always_comb begin
    hw_set    = '0;
    hw_set[0] = tb_hit;
    hw_set[1] = ref_hit;
    hw_set[2] = tin_hit;
    hw_set[3] = spread_enable & spread_reload;
    // Each high cycle of an end-of-count pulse sets its flag
    // timer end of count
    hw_set[4] = timer_zero_eoc;
    hw_set[5] = timer_one_eoc;
  end

  // ****************************************************************
  // Priority resolution
  // ****************************************************************
  logic           pick_valid;
  logic [2:0]     pick_win;
  logic [SRC-1:0] enabled_req;

  assign enabled_req = s_q.mask[`MASK_GLOBAL] ? (s_q.req & s_q.mask[SRC-1:0]) : '0;

  // Values above five fall back to source zero
  // programmable priority
  prio_pick #(
    .N (SRC)
  ) u_pick (
    .pend  (enabled_req),
    .start (s_q.prio),
    .valid (pick_valid),
    .win   (pick_win)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic wr_hit;
  logic vec_clear;

  always_comb begin
    s_d       = s_q;
    vec_clear = 1'b0;
    wr_hit    = reg_req.wr;
    s_d.rdata = 8'h00;
    s_d.load  = 1'b0;

    // ****************************************************************
    // Register writes
    // ****************************************************************
    if (wr_hit) begin
      case (reg_req.addr)
        `OFS_REQUEST: begin
          s_d.req      = reg_req.wdata[SRC-1:0];
          s_d.edge_sel = reg_req.wdata[`REQ_EDGE_LO +: 2];
        end
        `OFS_MASK: begin
          s_d.mask = reg_req.wdata;
        end
        `OFS_PRIORITY: begin
          s_d.prio = reg_req.wdata[2:0];
        end
        `OFS_PORT3_MODE: begin
          s_d.analog = reg_req.wdata[`P3M_ANALOG];
        end
        `OFS_EVT_CLEAR: begin
          s_d.evt = s_q.evt & ~reg_req.wdata[`EVT_WIDTH-1:0];
        end
        `OFS_EVT_ENABLE: begin
          s_d.evt_en = reg_req.wdata[`EVT_WIDTH-1:0];
        end
        // Status and pin state are read-only, writes are dropped
        `OFS_PIN_STATE, `OFS_EVT_STAT: begin
        end
        default: begin
        end
      endcase
    end

    // ****************************************************************
    // Register reads, data in the following cycle only
    // ****************************************************************
    // Reads have no side effects, so a polled flag stays set
    if (reg_req.rd) begin
      case (reg_req.addr)
        `OFS_REQUEST:    s_d.rdata = {s_q.edge_sel, s_q.req};
        `OFS_MASK:       s_d.rdata = s_q.mask;
        `OFS_PRIORITY:   s_d.rdata = {5'h00, s_q.prio};
        `OFS_PORT3_MODE: s_d.rdata = {6'h00, s_q.analog, 1'b0};
        `OFS_PIN_STATE:  s_d.rdata = {6'h00, tin_level, ref_level};
        `OFS_EVT_STAT:   s_d.rdata = {1'b0, s_q.evt};
        `OFS_EVT_ENABLE: s_d.rdata = {1'b0, s_q.evt_en};
        default:         s_d.rdata = 8'h00;
      endcase
    end

    // ****************************************************************
    // Interrupt machine cycle
    // ****************************************************************
    // interrupt machine cycle
    case (s_q.st)
      ST_IDLE: begin
        if (pick_valid && core_int_ok) begin
          s_d.st                 = ST_SAVE;
          s_d.win                = pick_win;
          vec_clear              = 1'b1;
          // Further grants wait until software re-enables
          s_d.mask[`MASK_GLOBAL] = 1'b0;
        end
      end
      ST_SAVE: begin
        // Core saves counter and flags in this cycle
        // first vector byte address
        s_d.st      = ST_FETCH_HI;
        s_d.pm_addr = vec_base(s_q.win);
      end
      ST_FETCH_HI: begin
        s_d.st      = ST_FETCH_LO;
        s_d.pm_addr = vec_base(s_q.win) | 16'h0001;
      end
      ST_FETCH_LO: begin
        s_d.st     = ST_LOAD;
        s_d.vec_hi = pm_rdata;
      end
      ST_LOAD: begin
        s_d.st   = ST_IDLE;
        s_d.load = 1'b1;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase

    if (s_q.st == ST_LOAD) begin
      s_d.isr = {s_q.vec_hi, pm_rdata};
    end

    // ****************************************************************
    // Flag and event update
    // ****************************************************************
    // flag cleared when its cycle is taken
    if (vec_clear) begin
      s_d.req[pick_win] = 1'b0;
    end

    s_d.req = s_d.req | hw_set;

    // Event status: a new event beats a clear in the same cycle
    s_d.evt = s_d.evt | {vec_clear, hw_set};
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata     = s_q.rdata;
  assign int_pending   = pick_valid;
  assign core_save_ctx = (s_q.st == ST_SAVE);
  assign pm_req.addr   = s_q.pm_addr;
  assign pm_req.rd     = (s_q.st == ST_FETCH_HI) || (s_q.st == ST_FETCH_LO);
  assign irq_out       = |(s_q.evt & s_q.evt_en);

  // The load strobe rises with the new address, one cycle after the second byte.
  // The address then stands until the load step of the next grant, so a late core still sees it.
  assign core_load_pc  = s_q.load;
  assign isr_addr      = s_q.isr;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      // Edge detectors restart unprimed, so no request follows reset
      s_q.req      <= SRC'(`RST_REQUEST);
      s_q.edge_sel <= 2'b00;
      s_q.mask     <= `RST_MASK;
      s_q.prio     <= `RST_PRIORITY;
      s_q.analog   <= 1'b0;
      s_q.evt      <= `RST_EVT;
      s_q.evt_en   <= `RST_EVT;
      s_q.rdata    <= 8'h00;
      s_q.st       <= ST_IDLE;
      s_q.win      <= 3'h0;
      s_q.vec_hi   <= 8'h00;
      s_q.isr      <= 16'h0000;
      s_q.pm_addr  <= 16'h0000;
      s_q.load     <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : irq_ctrl
`default_nettype wire

// [dv/irq_pm_model.sv]
// Program memory model answering vector fetches
`timescale 1ns/1ps
`default_nettype none
module irq_pm_model
  import irq_ctrl_pkg::*;
(
  // Clock
  input  wire logic    ref_clk,
  // Fetch port
  input  wire pm_req_t pm_req,
  output logic [7:0]   pm_rdata
);
  logic [7:0] data_q = 8'h00;
  assign pm_rdata = data_q;
  // vector table bytes
  // Idle cycles flip the bus so stale data shows inverted every other cycle
  always @(posedge ref_clk) begin
    if (pm_req.rd) begin
      data_q <= 8'h50 + pm_req.addr[7:0];
    end else begin
      data_q <= ~data_q;
    end
  end
endmodule : irq_pm_model
`default_nettype wire

// [dv/irq_ctrl_props.sv]
// Port assertions for the interrupt controller
`include "irq_ctrl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_props
  import irq_ctrl_pkg::*;
#(
  parameter int unsigned SRC = 6
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // Register port
  input wire reg_req_t    reg_req,
  input wire logic        comparator_power,
  // Core and vector fetch
  input wire logic        core_int_ok,
  input wire logic        int_pending,
  input wire logic        core_save_ctx,
  input wire logic        core_load_pc,
  input wire logic [15:0] isr_addr,
  input wire pm_req_t     pm_req,
  input wire logic [7:0]  pm_rdata
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence fetch_hi_s;
    pm_req.rd && !pm_req.addr[0];
  endsequence
  sequence fetch_lo_s;
    pm_req.rd && pm_req.addr == $past(pm_req.addr) + 16'h0001;
  endsequence

  save_fetch_a: assert property ($rose(core_save_ctx) |=> fetch_hi_s ##1 fetch_lo_s)
    else $error("vector fetch did not follow context save");
  grant_cause_a: assert property (core_save_ctx |-> $past(int_pending) && $past(core_int_ok))
    else $error("context save without a granted request");
  save_pulse_a: assert property (core_save_ctx |=> !core_save_ctx)
    else $error("context save longer than one cycle");
  save_disable_a: assert property (core_save_ctx |=> !int_pending)
    else $error("interrupts still enabled after grant");
  vector_range_a: assert property (pm_req.rd |-> pm_req.addr <= 16'h000B)
    else $error("vector fetch outside the table");
  isr_value_a: assert property (core_save_ctx |-> ##4 isr_addr == {$past(pm_rdata, 2), $past(pm_rdata)})
    else $error("routine address not built from vector bytes");
  load_strobe_a: assert property (core_save_ctx |-> ##3 !core_load_pc ##1 core_load_pc)
    else $error("routine load strobe not with the new address");
  global_mask_a: assert property (reg_req.wr && reg_req.addr == `OFS_MASK && !reg_req.wdata[7] |=> !int_pending)
    else $error("request pending with global enable off");
  comp_power_a: assert property (reg_req.wr && reg_req.addr == `OFS_PORT3_MODE
                                 |=> comparator_power == $past(reg_req.wdata[1]))
    else $error("comparator power does not follow mode bit");
endmodule : irq_ctrl_props

bind irq_ctrl irq_ctrl_props #(.SRC(SRC)) u_props (
  .ref_clk, .sys_rst, .reg_req, .comparator_power, .core_int_ok,
  .int_pending, .core_save_ctx, .core_load_pc, .isr_addr, .pm_req, .pm_rdata
);
`default_nettype wire

// [dv/irq_ctrl_bench.sv]
// Self-checking bench for the interrupt controller
`include "irq_ctrl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_bench
  import irq_ctrl_pkg::*;
;
  logic ref_clk = 1'b0, sys_rst = 1'b1;
  reg_req_t reg_req = '0;
  logic [7:0] reg_rdata, pm_rdata;
  logic reference_pin = 1'b1, analog_timer_pin = 1'b0, comparator_out = 1'b0, stop_recovery_src = 1'b1;
  logic time_base_level = 1'b0, timer_zero_eoc = 1'b0, timer_one_eoc = 1'b0;
  logic spread_enable = 1'b0, spread_reload = 1'b0, core_int_ok = 1'b0;
  logic comparator_power, int_pending, core_save_ctx, core_load_pc, irq_out;
  logic [15:0] isr_addr;
  pm_req_t pm_req;
  int n_fail = 0, n_compared = 0;

  always #2 ref_clk = ~ref_clk;

  irq_ctrl uut (
    .ref_clk, .sys_rst, .reg_req, .reg_rdata, .reference_pin, .analog_timer_pin,
    .comparator_out, .stop_recovery_src, .time_base_level, .timer_zero_eoc,
    .timer_one_eoc, .spread_enable, .spread_reload, .comparator_power, .core_int_ok,
    .int_pending, .core_save_ctx, .core_load_pc, .isr_addr, .pm_req, .pm_rdata, .irq_out
  );
  irq_pm_model u_pm (.ref_clk, .pm_req, .pm_rdata);

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    reg_req <= '0;
    #1;
    chk(what, reg_rdata, exp);
  endtask : rd
  function automatic logic [7:0] vec(input int a);
    return 8'h50 + a[7:0];
  endfunction : vec
  task automatic give_verdict();
    if (n_fail == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    logic [1:0] sel;
    int w;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(`OFS_REQUEST, 8'h00, "request reset");
    rd(`OFS_MASK, 8'h00, "mask reset");
    rd(4'hF, 8'h00, "unmapped read");
    @(posedge ref_clk) reference_pin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd(`OFS_REQUEST, 8'h02, "reference fall");
    chk("masked pending", int_pending, 1'b0);
    @(posedge ref_clk) reference_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(`OFS_REQUEST, 8'h02, "reference rise kept");
    wr(`OFS_REQUEST, 8'h00);
    @(posedge ref_clk) timer_zero_eoc <= 1'b1;
    @(posedge ref_clk) timer_zero_eoc <= 1'b0;
    timer_one_eoc <= 1'b1;
    @(posedge ref_clk) timer_one_eoc <= 1'b0;
    @(posedge ref_clk) spread_reload <= 1'b1;
    @(posedge ref_clk) spread_reload <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(`OFS_REQUEST, 8'h30, "timer ends only");
    wr(`OFS_REQUEST, 8'h08);
    rd(`OFS_REQUEST, 8'h08, "software spread");
    wr(`OFS_REQUEST, 8'h00);
    @(posedge ref_clk) spread_enable <= 1'b1;
    @(posedge ref_clk) spread_reload <= 1'b1;
    @(posedge ref_clk) spread_reload <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(`OFS_REQUEST, 8'h08, "reload enabled");
    // Every edge pair code, rising then falling on both inputs
    for (int s = 0; s < 4; s++) begin
      sel = s[1:0];
      wr(`OFS_REQUEST, {sel, 6'h00});
      @(posedge ref_clk) analog_timer_pin <= 1'b1;
      time_base_level <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(`OFS_REQUEST, {sel, 3'h0, sel[1], 1'b0, sel[0]}, "rising edges");
      wr(`OFS_REQUEST, {sel, 6'h00});
      @(posedge ref_clk) analog_timer_pin <= 1'b0;
      time_base_level <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rd(`OFS_REQUEST, {sel, 3'h0, s != 2, 1'b0, s != 1}, "falling edges");
    end
    wr(`OFS_REQUEST, 8'hC0);
    wr(`OFS_PORT3_MODE, 8'h02);
    #1 chk("comparator on", comparator_power, 1'b1);
    @(posedge ref_clk) reference_pin <= 1'b0;
    analog_timer_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(`OFS_REQUEST, 8'hC0, "digital pins ignored");
    @(posedge ref_clk) stop_recovery_src <= 1'b0;
    comparator_out <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(`OFS_REQUEST, 8'hC6, "analog sources");
    @(posedge ref_clk) reference_pin <= 1'b1;
    analog_timer_pin <= 1'b0;
    stop_recovery_src <= 1'b1;
    comparator_out <= 1'b0;
    repeat (4) @(posedge ref_clk);
    wr(`OFS_PORT3_MODE, 8'h00);
    #1 chk("comparator off", comparator_power, 1'b0);
    wr(`OFS_EVT_ENABLE, 8'h40);
    wr(`OFS_REQUEST, 8'hC1);
    wr(`OFS_MASK, 8'h82);
    #1 chk("other source masked", int_pending, 1'b0);
    wr(`OFS_MASK, 8'h81);
    #1 chk("own source open", int_pending, 1'b1);
    // Full contention, each priority start, one out of range
    for (int p = 0; p < 7; p++) begin
      w = (p > 5) ? 0 : p;
      wr(`OFS_MASK, 8'h3F);
      wr(`OFS_REQUEST, 8'hFF);
      wr(`OFS_PRIORITY, p[7:0]);
      wr(`OFS_EVT_CLEAR, 8'h7F);
      @(posedge ref_clk) core_int_ok <= 1'b1;
      wr(`OFS_MASK, 8'hBF);
      for (int i = 0; i < 20 && core_save_ctx !== 1'b1; i++) begin
        @(posedge ref_clk);
        #1;
      end
      chk("grant", core_save_ctx, 1'b1);
      repeat (4) @(posedge ref_clk);
      core_int_ok <= 1'b0;
      #1 chk("isr address", isr_addr, {vec(2 * w), vec(2 * w + 1)});
      chk("routine load", core_load_pc, 1'b1);
      rd(`OFS_REQUEST, 8'hFF & ~(8'h01 << w), "taken flag");
      rd(`OFS_MASK, 8'h3F, "global disabled");
      rd(`OFS_EVT_STAT, 8'h40, "vector event");
      chk("event line", irq_out, 1'b1);
    end
    wr(`OFS_EVT_ENABLE, 8'h00);
    #1 chk("event masked", irq_out, 1'b0);
    wr(`OFS_EVT_CLEAR, 8'h40);
    rd(`OFS_EVT_STAT, 8'h00, "event cleared");
    give_verdict();
  end

  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end
endmodule : irq_ctrl_bench
`default_nettype wire
